// >>> ttmc_panel.sv
// Purpose: operator panels, local cluster and remote unit
// Assumes: operator stands at one panel at a time
// Notes: the unused panel shows no press
`timescale 1ns/1ps
module ttmc_panel
  import ttmc_pkg::*;
(
  // operator action
  input wire logic [4:0] i_hold,
  input wire logic i_at_remote,
  // panel contacts
  output ttmc_pkg::ttmc_buttons_s o_local,
  output ttmc_pkg::ttmc_buttons_s o_remote
);
  assign o_local = i_at_remote ? 5'h00 : i_hold;
  assign o_remote = i_at_remote ? i_hold : 5'h00;
endmodule : ttmc_panel

// >>> ttmc_pkg.sv
// Purpose: shared constants and types for the tape transport mode controller
// Assumes: 25 MHz system clock
// Notes: register offsets are byte addresses on classic wishbone
package ttmc_pkg;

  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BRAKE_TIME_MS = 4000;
  localparam int BRAKE_CYCLES = (CLK_HZ / 1000) * BRAKE_TIME_MS;
  localparam int DEBOUNCE_TIME_US = 5000;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_TIME_US;

  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BUTTONS = 8'h08;

  // control register fields
  localparam int CTRL_SPEED_LSB = 0;
  localparam int CTRL_SPEED_W = 3;
  localparam int CTRL_REMOTE_BIT = 4;
  localparam int CTRL_REMOTE_OVR_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // speed selection: six speeds, codes 0 (fastest) to 5
  localparam int NUM_SPEEDS = 6;
  localparam logic [2:0] SPEED_MAX = 3'h5;

  // button indices
  localparam int NUM_BTN = 5;
  localparam int BTN_STOP = 4;
  localparam int BTN_DRIVE = 3;
  localparam int BTN_RECORD = 2;
  localparam int BTN_FWD = 1;
  localparam int BTN_REV = 0;

  // unmapped read value
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_STOP,
    MODE_BRAKE,
    MODE_DRIVE,
    MODE_RECORD,
    MODE_FORWARD,
    MODE_REWIND,
    MODE_SEARCH
  } ttmc_mode_e;

  typedef struct packed {
    logic stop_btn;
    logic drive_btn;
    logic record_btn;
    logic fast_forward_button;
    logic fast_reverse_button;
  } ttmc_buttons_s;

  typedef struct packed {
    logic lifters_extend;
    logic pinch_engage;
    logic brakes_apply;
    logic holdback_on;
    logic takeup_full;
    logic takeup_low;
    logic supply_full;
    logic supply_low;
    logic record_enable;
    logic reproduce_enable;
    logic capstan_run;
  } ttmc_actuators_s;

  typedef struct packed {
    logic stop;
    logic drive;
    logic record;
    logic forward;
    logic rewind;
    logic search;
  } ttmc_lamps_s;

endpackage : ttmc_pkg

// >>> ttmc_sva.sv
// Purpose: port checker for the mode controller
// Assumes: bound to ttmc_top
// Notes: lamp state decides the actuator pattern
`timescale 1ns/1ps
module ttmc_sva
  import ttmc_pkg::*;
#(
  parameter int DEBOUNCE = 2
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // bus handshake
  input wire logic i_CYC,
  input wire logic i_STB,
  input wire logic o_ACK,
  // sensor and outputs
  input wire logic i_END_OF_TAPE,
  input wire ttmc_pkg::ttmc_actuators_s o_ACT,
  input wire ttmc_pkg::ttmc_lamps_s o_LAMPS,
  input wire logic [2:0] o_CAPSTAN_SPEED
);
  int eot_q;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || !i_END_OF_TAPE) eot_q <= 0;
    else if (eot_q < 1000) eot_q <= eot_q + 1;
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  chk_ack_pulse: assert property (
    i_CYC && i_STB && !o_ACK |=> o_ACK ##1 !o_ACK) else $error("ack late");
  chk_stop_state: assert property (
    o_LAMPS.stop |-> o_ACT.lifters_extend && o_ACT.brakes_apply &&
    !o_ACT.pinch_engage && !o_ACT.holdback_on && o_ACT.capstan_run)
    else $error("stop actuators wrong");
  chk_drive_state: assert property (
    o_LAMPS.drive |-> o_ACT.pinch_engage && !o_ACT.lifters_extend &&
    o_ACT.holdback_on && o_ACT.takeup_low && !o_ACT.supply_full &&
    !o_ACT.supply_low && !o_ACT.brakes_apply) else $error("drive wrong");
  chk_rec_state: assert property (
    o_LAMPS.record |-> o_ACT.record_enable && o_ACT.reproduce_enable &&
    o_ACT.pinch_engage && !o_ACT.lifters_extend && !o_ACT.brakes_apply)
    else $error("record wrong");
  chk_fwd_state: assert property (
    o_LAMPS.forward |-> o_ACT.lifters_extend && !o_ACT.pinch_engage &&
    !o_ACT.holdback_on && o_ACT.takeup_full && o_ACT.supply_low)
    else $error("forward wrong");
  chk_rew_state: assert property (
    o_LAMPS.rewind |-> o_ACT.lifters_extend && !o_ACT.pinch_engage &&
    o_ACT.supply_full && o_ACT.takeup_low && !o_ACT.takeup_full)
    else $error("rewind wrong");
  chk_search_heads: assert property (
    o_LAMPS.search |-> !o_ACT.lifters_extend) else $error("lifters out");
  chk_one_lamp: assert property (
    $onehot0(o_LAMPS)) else $error("several lamps lit");
  chk_rec_entry: assert property (
    $rose(o_LAMPS.record) |-> $past(o_LAMPS.drive))
    else $error("record not from drive");
  chk_brake_gap: assert property (
    !$past(I_RESET) && o_LAMPS == '0 |-> o_ACT.brakes_apply)
    else $error("unlit state without brakes");
  chk_eot_stop: assert property (
    eot_q > DEBOUNCE + 8 |-> o_LAMPS.stop) else $error("no stop at tape end");
  chk_speed_max: assert property (
    o_CAPSTAN_SPEED <= 3'h5) else $error("speed code out of range");
endmodule : ttmc_sva

bind ttmc_top ttmc_sva #(.DEBOUNCE(DEBOUNCE)) u_sva (
  .I_MCLK(I_MCLK), .I_RESET(I_RESET), .i_CYC(i_CYC), .i_STB(i_STB),
  .o_ACK(o_ACK), .i_END_OF_TAPE(i_END_OF_TAPE), .o_ACT(o_ACT),
  .o_LAMPS(o_LAMPS), .o_CAPSTAN_SPEED(o_CAPSTAN_SPEED));

// >>> ttmc_sync.sv
// Purpose: two-flop synchroniser plus debounce filter for one input
// Assumes: input is asynchronous to clk
// Notes: output changes only after the input is stable for the count
`timescale 1ns/1ps
module ttmc_sync #(
  parameter int DEBOUNCE = 125000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // raw and clean level
  input wire logic i_raw,
  output logic o_clean
);

  localparam int CW = $clog2(DEBOUNCE + 1);

  logic meta_q;
  logic sync_q;
  logic clean_q;
  logic [CW-1:0] cnt_q;
  wire differs = sync_q != clean_q;
  wire done = cnt_q == CW'(DEBOUNCE - 1);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_raw;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clean_q <= 1'b0;
      cnt_q <= '0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (done) begin
      clean_q <= sync_q;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign o_clean = clean_q;

endmodule : ttmc_sync

// >>> ttmc_top.sv
// Purpose: mode controller for a tape transport
// Assumes: 25 MHz I_MCLK, synchronous active-high I_RESET
// Notes: wishbone classic slave holds speed and local/remote select
//
// Overview of operation
// (R01) reset (power on) enters stop with no button pressed
// (R02) end-of-tape sensor active forces stop from any mode
// (R03) stop: lifters out, capstan runs, pinch off, brakes on, holdback off
// (R04) stop button selects stop from any mode
// (R05) each mode except brake lights its lamp; stop lamp off in other modes
// (R06) drive: capstan, pinch on, lifters in, holdback on, take-up only
// (R07) brakes released in drive; drive press from stop releases them, from forward or rewind only after braking
// (R08) drive from forward or rewind brakes reels four seconds first
// (R09) record enables record and reproduce, actuators as in drive
// (R10) record button ignored unless already in drive
// (R11) operator presses drive then record to record from stop
// (R12) forward: lifters out, pinch off, take-up full, supply low
// (R13) fast forward button selects forward mode
// (R14) fast reverse button selects rewind from any mode except search
// (R15) rewind is forward with torque roles swapped
// (R16) fast held then drive held in fast mode enters search, lifters off
// (R17) search: fast released with drive held goes to drive
// (R18) search: drive released with fast held returns to fast mode
// (R19) remote buttons act as local ones; no remote power control
// (R20) six speeds supported in every mode; capstan follows selection
// (R21) local/remote selector picks button source unless the control register override bit is set
// (R22) inputs synchronised and debounced; brake delay timed by counter
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
module ttmc_top
  import ttmc_pkg::*;
#(
  parameter int BRAKE_CNT = ttmc_pkg::BRAKE_CYCLES,
  parameter int DEBOUNCE = ttmc_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // wishbone classic slave
  input wire logic i_CYC,
  input wire logic i_STB,
  input wire logic i_WE,
  input wire logic [7:0] i_ADR,
  input wire logic [3:0] i_SEL,
  input wire logic [31:0] i_DAT,
  output logic [31:0] o_DAT,
  output logic o_ACK,
  // button panels and sensors
  input wire ttmc_pkg::ttmc_buttons_s i_LOCAL_BTN,
  input wire ttmc_pkg::ttmc_buttons_s i_REMOTE_BTN,
  input wire logic i_REMOTE_SELECT_POSITION,
  input wire logic i_END_OF_TAPE,
  // transport and lamps
  output ttmc_pkg::ttmc_actuators_s o_ACT,
  output ttmc_pkg::ttmc_lamps_s o_LAMPS,
  output logic [2:0] o_CAPSTAN_SPEED
);

  import ttmc_pkg::*;

  localparam int BCW = $clog2(BRAKE_CNT + 1);
  localparam int NIN = 2 * NUM_BTN + 2;

  // synchronised inputs
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] clean_in;
  assign raw_in = {i_END_OF_TAPE, i_REMOTE_SELECT_POSITION,
                   i_REMOTE_BTN, i_LOCAL_BTN};

  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      ttmc_sync #(.DEBOUNCE(DEBOUNCE)) u_sync ( // see (R22)
        .i_clk(I_MCLK),
        .i_rst(I_RESET),
        .i_raw(raw_in[g]),
        .o_clean(clean_in[g])
      );
    end
  endgenerate

  wire [NUM_BTN-1:0] loc_btn = clean_in[NUM_BTN-1:0];
  wire [NUM_BTN-1:0] rem_btn = clean_in[2*NUM_BTN-1:NUM_BTN];
  wire sw_remote = clean_in[2*NUM_BTN];
  wire eot = clean_in[2*NUM_BTN+1];

  // registers
  logic [31:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdat_q;

  wire wb_req = i_CYC && i_STB && !ack_q;
  wire wb_wr = i_CYC && i_STB && i_WE && ack_q;
  wire hit_ctrl = i_ADR == ADDR_CTRL;
  wire hit_status = i_ADR == ADDR_STATUS;
  wire hit_btn = i_ADR == ADDR_BUTTONS;
  wire remote_ovr = ctrl_q[CTRL_REMOTE_OVR_BIT];
  wire remote_en = remote_ovr ? ctrl_q[CTRL_REMOTE_BIT] : sw_remote;
  wire [2:0] speed_raw = ctrl_q[CTRL_SPEED_LSB +: CTRL_SPEED_W];
  wire [2:0] speed_sel = (speed_raw > SPEED_MAX) ? SPEED_MAX : speed_raw;

  // button source; remote panel has identical buttons, no power control
  wire [NUM_BTN-1:0] btn = remote_en ? rem_btn : loc_btn; // see (R19) (R21)

  logic [NUM_BTN-1:0] btn_prev_q;
  wire [NUM_BTN-1:0] press = btn & ~btn_prev_q;

  wire p_stop = press[BTN_STOP];
  wire p_drive = press[BTN_DRIVE];
  wire p_record = press[BTN_RECORD];
  wire p_fwd = press[BTN_FWD];
  wire p_rev = press[BTN_REV];
  wire h_drive = btn[BTN_DRIVE];
  wire h_fwd = btn[BTN_FWD];
  wire h_rev = btn[BTN_REV];

  // mode machine
  ttmc_mode_e mode_q;
  ttmc_mode_e mode_d;
  logic search_fwd_q;
  logic search_fwd_d;
  logic [BCW-1:0] brake_cnt_q;
  wire brake_done = brake_cnt_q == BCW'(BRAKE_CNT - 1);
  wire fast_mode = mode_q == MODE_FORWARD || mode_q == MODE_REWIND;

  always_comb begin
    mode_d = mode_q;
    search_fwd_d = search_fwd_q;
    case (mode_q)
      MODE_STOP: begin
        if (p_drive) begin
          mode_d = MODE_DRIVE;
        end else if (p_fwd) begin
          mode_d = MODE_FORWARD; // see (R13)
        end else if (p_rev) begin
          mode_d = MODE_REWIND; // see (R14)
        end
      end
      MODE_BRAKE: begin
        if (p_fwd) begin
          mode_d = MODE_FORWARD;
        end else if (p_rev) begin
          mode_d = MODE_REWIND;
        end else if (brake_done) begin
          mode_d = MODE_DRIVE; // see (R08)
        end
      end
      MODE_DRIVE: begin
        if (p_record) begin
          mode_d = MODE_RECORD; // see (R10) (R11)
        end else if (p_fwd) begin
          mode_d = MODE_FORWARD;
        end else if (p_rev) begin
          mode_d = MODE_REWIND;
        end
      end
      MODE_RECORD: begin
        if (p_fwd) begin
          mode_d = MODE_FORWARD;
        end else if (p_rev) begin
          mode_d = MODE_REWIND;
        end
      end
      MODE_FORWARD, MODE_REWIND: begin
        if ((h_fwd && mode_q == MODE_FORWARD ||
             h_rev && mode_q == MODE_REWIND) && p_drive) begin
          mode_d = MODE_SEARCH; // see (R16)
          search_fwd_d = mode_q == MODE_FORWARD;
        end else if (p_drive) begin
          mode_d = MODE_BRAKE; // see (R08)
        end else if (p_fwd) begin
          mode_d = MODE_FORWARD;
        end else if (p_rev) begin
          mode_d = MODE_REWIND;
        end
      end
      MODE_SEARCH: begin
        if (!(search_fwd_q ? h_fwd : h_rev)) begin
          mode_d = h_drive ? MODE_DRIVE : MODE_STOP; // see (R17)
        end else if (!h_drive) begin
          mode_d = search_fwd_q ? MODE_FORWARD : MODE_REWIND; // see (R18)
        end
      end
      default: begin
        mode_d = MODE_STOP;
      end
    endcase
    if (p_stop || eot) begin
      mode_d = MODE_STOP; // see (R02) (R04)
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      mode_q <= MODE_STOP; // see (R01)
      search_fwd_q <= 1'b0;
      btn_prev_q <= '0;
    end else begin
      mode_q <= mode_d;
      search_fwd_q <= search_fwd_d;
      btn_prev_q <= btn;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET || mode_q != MODE_BRAKE) begin
      brake_cnt_q <= '0;
    end else if (!brake_done) begin
      brake_cnt_q <= brake_cnt_q + BCW'(1); // see (R22)
    end
  end

  // actuator decode
  ttmc_actuators_s act_d;
  ttmc_lamps_s lamp_d;
  wire m_drive = mode_d == MODE_DRIVE || mode_d == MODE_RECORD;
  wire m_fwd = mode_d == MODE_FORWARD ||
               (mode_d == MODE_SEARCH && search_fwd_d);
  wire m_rew = mode_d == MODE_REWIND ||
               (mode_d == MODE_SEARCH && !search_fwd_d);
  wire m_brk = mode_d == MODE_STOP || mode_d == MODE_BRAKE;

  assign act_d.lifters_extend = m_brk || mode_d == MODE_FORWARD ||
                                mode_d == MODE_REWIND; // see (R03) (R16)
  assign act_d.pinch_engage = m_drive; // see (R06)
  assign act_d.brakes_apply = m_brk; // see (R03) (R07)
  assign act_d.holdback_on = m_drive; // see (R06)
  assign act_d.takeup_full = m_fwd; // see (R12)
  assign act_d.takeup_low = m_drive || m_rew; // see (R06) (R15)
  assign act_d.supply_full = m_rew; // see (R15)
  assign act_d.supply_low = m_fwd; // see (R12)
  assign act_d.record_enable = mode_d == MODE_RECORD; // see (R09)
  assign act_d.reproduce_enable = 1'b1;
  assign act_d.capstan_run = 1'b1; // see (R03) (R20)

  assign lamp_d.stop = mode_d == MODE_STOP; // see (R05)
  assign lamp_d.drive = mode_d == MODE_DRIVE;
  assign lamp_d.record = mode_d == MODE_RECORD;
  assign lamp_d.forward = mode_d == MODE_FORWARD;
  assign lamp_d.rewind = mode_d == MODE_REWIND;
  assign lamp_d.search = mode_d == MODE_SEARCH;

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      o_ACT <= '0;
      o_LAMPS <= '0;
      o_CAPSTAN_SPEED <= '0;
    end else begin
      o_ACT <= act_d;
      o_LAMPS <= lamp_d;
      o_CAPSTAN_SPEED <= speed_sel; // see (R20)
    end
  end

  // wishbone slave
  wire [31:0] status_word = {13'h0000, remote_en, eot,
                             o_LAMPS, 4'h0, speed_sel, 1'b0,
                             mode_q};
  wire [31:0] btn_word = {22'h00_0000, rem_btn, loc_btn};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_status ? status_word :
                       hit_btn ? btn_word : READ_ZERO;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
          ctrl_q[8*b +: 8] <= CTRL_RESET[8*b +: 8];
        end else if (wb_wr && hit_ctrl && i_SEL[b]) begin
          ctrl_q[8*b +: 8] <= i_DAT[8*b +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= wb_req;
      rdat_q <= wb_req ? rd_mux : READ_ZERO;
    end
  end

  assign o_ACK = ack_q;
  assign o_DAT = rdat_q;

endmodule : ttmc_top

// >>> ttmc_top_tb.sv
// Purpose: self-checking bench for the mode controller
// Assumes: short brake and debounce counts
// Notes: operator acts through the panel model
`timescale 1ns/1ps
module ttmc_top_tb;
  import ttmc_pkg::*;
  localparam int BRK = 20;
  localparam logic [5:0] L_STP = 6'h20, L_DRV = 6'h10, L_REC = 6'h08;
  localparam logic [5:0] L_FWD = 6'h04, L_REW = 6'h02, L_SRC = 6'h01;
  localparam logic [4:0] B_STP = 5'h10, B_DRV = 5'h08, B_REC = 5'h04;
  localparam logic [4:0] B_FF = 5'h02, B_FR = 5'h01;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, at_rem = 0;
  logic eot = 0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [4:0] hold = '0;
  logic [5:0] lamps;
  logic [2:0] spd;
  ttmc_buttons_s loc, rem;
  ttmc_actuators_s act;
  int err_count = 0, comparisons = 0, cycles = 0;
  ttmc_panel panel (.i_hold(hold), .i_at_remote(at_rem), .o_local(loc),
    .o_remote(rem));
  ttmc_top #(.BRAKE_CNT(BRK), .DEBOUNCE(2)) dut (
    .I_MCLK(clk), .I_RESET(rst), .i_CYC(cyc), .i_STB(stb), .i_WE(we),
    .i_ADR(adr), .i_SEL(sel), .i_DAT(wdat), .o_DAT(rdat), .o_ACK(ack),
    .i_LOCAL_BTN(loc), .i_REMOTE_BTN(rem), .i_REMOTE_SELECT_POSITION(at_rem),
    .i_END_OF_TAPE(eot), .o_ACT(act), .o_LAMPS(lamps), .o_CAPSTAN_SPEED(spd));
  task automatic report_and_stop;
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  task automatic push(input logic [4:0] b);
    @(posedge clk);
    hold <= b;
  endtask : push
  task automatic look(input logic [5:0] e, input int lim);
    int n;
    n = 0;
    while (lamps !== e && n < lim) begin
      @(posedge clk);
      n++;
    end
    check("lamps", 32'(lamps), 32'(e));
  endtask : look
  task automatic tap(input logic [4:0] b, input logic [5:0] e);
    push(b);
    repeat (8) @(posedge clk);
    look(e, 20);
    push(0);
    repeat (10) @(posedge clk);
  endtask : tap
  task automatic t_regs;
    for (int s = 0; s < 8; s++) begin
      wb(1, ADDR_CTRL, s);
      wb(0, ADDR_CTRL, 0);
      if (s < 6) check("ctrl", q, 32'(s));
      check("speed", 32'(spd), s > 5 ? 32'h5 : 32'(s));
    end
    wb(0, 8'h0c, 0);
    check("unmapped", q, '0);
    wb(0, ADDR_STATUS, 0);
    check("status", q, 32'h0001_0050);
    push(B_REC);
    repeat (8) @(posedge clk);
    wb(0, ADDR_BUTTONS, 0);
    check("buttons", q, 32'h0000_0004);
    push(0);
    repeat (10) @(posedge clk);
  endtask : t_regs
  task automatic t_record;
    tap(B_REC, L_STP);
    look(L_STP, 0);
    tap(B_DRV, L_DRV);
    tap(B_REC, L_REC);
    check("rec_en", 32'(act.record_enable), 1);
    tap(B_STP, L_STP);
    check("act", 32'(act), 32'h503);
  endtask : t_record
  task automatic t_brake;
    int n;
    for (int i = 0; i < 2; i++) begin
      tap(i ? B_FR : B_FF, i ? L_REW : L_FWD);
      push(B_DRV);
      look(0, 20);
      n = 0;
      while (lamps !== L_DRV && n < 100) begin
        @(posedge clk);
        n++;
      end
      check("brake", 32'(n >= BRK - 3 && n <= BRK + 3), 1);
      tap(0, L_DRV);
    end
  endtask : t_brake
  task automatic t_search;
    logic [4:0] f;
    for (int i = 0; i < 2; i++) begin
      f = i ? B_FF : B_FR;
      tap(f, i ? L_FWD : L_REW);
      push(f);
      repeat (12) @(posedge clk);
      push(f | B_DRV);
      look(L_SRC, 20);
      push(i ? B_DRV : f);
      if (i) look(L_DRV, 60);
      else look(L_REW, 20);
      tap(0, i ? L_DRV : L_REW);
      tap(B_STP, L_STP);
    end
  endtask : t_search
  task automatic t_eot;
    tap(B_DRV, L_DRV);
    @(posedge clk);
    eot <= 1;
    look(L_STP, 20);
    tap(B_DRV, L_STP);
    look(L_STP, 0);
    @(posedge clk);
    eot <= 0;
  endtask : t_eot
  task automatic t_remote;
    @(posedge clk);
    at_rem <= 1;
    repeat (10) @(posedge clk);
    tap(B_DRV, L_DRV);
    tap(B_STP, L_STP);
    at_rem <= 0;
    wb(1, ADDR_CTRL, 32'h0000_0035);
    tap(B_DRV, L_STP);
    wb(1, ADDR_CTRL, 32'h0000_0005);
    tap(B_DRV, L_DRV);
    tap(B_STP, L_STP);
  endtask : t_remote
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    look(L_STP, 4);
    check("act", 32'(act), 32'h503);
    t_regs();
    t_record();
    t_brake();
    t_search();
    t_eot();
    t_remote();
    report_and_stop();
  end
endmodule : ttmc_top_tb
